// ---- rtl/sram_host_ctrl.sv ----
module sram_host_ctrl
   import sram_host_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   // clock and reset
   input  wire logic          clock,
   input  wire logic          srst,
   // user request
   input  wire logic          req_valid,
   output logic               req_ready,
   input  wire logic          req_write,
   input  wire logic [AW-1:0] req_addr,
   input  wire logic [DW-1:0] req_wdata,
   output logic               rsp_valid,
   output logic [DW-1:0]      rsp_rdata,
   // memory pins
   output logic [AW-1:0]      mem_addr,
   output logic               chip_select_low_active_n,
   output logic               chip_select_high_active,
   output logic               output_enable_n,
   output logic               write_strobe_n,
   input  wire logic [DW-1:0] mem_data_in,
   output logic [DW-1:0]      mem_data_out,
   output logic               mem_data_oe
);

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_READ  = 3'b001,
      ST_SETUP = 3'b010,
      ST_WRITE = 3'b011,
      ST_END   = 3'b100
   } state_e;

   typedef struct packed {
      state_e        state;
      logic [3:0]    cnt;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic [DW-1:0] rdata;
      logic          rvalid;
      logic          cs_n;
      logic          cs;
      logic          oe_n;
      logic          we_n;
      logic          doe;
   } ctrl_s;

   ctrl_s st_ff;
   ctrl_s nxt_st;

   function automatic logic [3:0] cyc(input int n);
      cyc = (n < 1) ? CNT_ONE : 4'(n);
   endfunction

   always_comb begin
      nxt_st        = st_ff;
      nxt_st.rvalid = 1'b0;
      case (st_ff.state)
         ST_IDLE: begin
            // idle: deselected, strobes high, bus released
            nxt_st.cs_n = 1'b1;
            nxt_st.cs   = 1'b0;
            nxt_st.oe_n = 1'b1;
            nxt_st.we_n = 1'b1;
            nxt_st.doe  = 1'b0;
            if (req_valid) begin
               // address moves only while strobe is high
               nxt_st.addr  = req_addr;
               nxt_st.wdata = req_wdata;
               nxt_st.cs_n  = 1'b0;
               nxt_st.cs    = 1'b1;
               if (req_write) begin
                  // output disable kept high; pulse sized for the larger of T_WP_PS and T_WHZ_PS + T_DW_PS
                  nxt_st.state = ST_SETUP;
                  nxt_st.cnt   = cyc(TURN_CYC);
               end else begin
                  nxt_st.oe_n  = 1'b0;
                  nxt_st.state = ST_READ;
                  nxt_st.cnt   = cyc(ACCESS_CYC);
               end
            end
         end
         ST_READ: begin
            if (st_ff.cnt == CNT_ONE) begin
               nxt_st.rdata  = mem_data_in;
               nxt_st.rvalid = 1'b1;
               nxt_st.oe_n   = 1'b1;
               nxt_st.cs_n   = 1'b1;
               nxt_st.cs     = 1'b0;
               nxt_st.state  = ST_END;
               nxt_st.cnt    = cyc(TURN_CYC);
            end else begin
               nxt_st.cnt = st_ff.cnt - CNT_ONE;
            end
         end
         ST_SETUP: begin
            // wait out any device drive before taking the bus
            if (st_ff.cnt == CNT_ONE) begin
               nxt_st.doe   = 1'b1;
               nxt_st.we_n  = 1'b0;
               nxt_st.state = ST_WRITE;
               nxt_st.cnt   = cyc(WP_CYC);
            end else begin
               nxt_st.cnt = st_ff.cnt - CNT_ONE;
            end
         end
         ST_WRITE: begin
            if (st_ff.cnt == CNT_ONE) begin
               nxt_st.we_n  = 1'b1;
               nxt_st.state = ST_END;
               nxt_st.cnt   = CNT_ONE;
            end else begin
               nxt_st.cnt = st_ff.cnt - CNT_ONE;
            end
         end
         ST_END: begin
            // data held one cycle past strobe rise for hold time
            nxt_st.doe  = 1'b0;
            nxt_st.cs_n = 1'b1;
            nxt_st.cs   = 1'b0;
            if (st_ff.cnt == CNT_ONE) begin
               nxt_st.state = ST_IDLE;
            end else begin
               nxt_st.cnt = st_ff.cnt - CNT_ONE;
            end
         end
         default: nxt_st.state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         st_ff       <= '0;
         st_ff.state <= ST_IDLE;
         st_ff.cs_n  <= 1'b1;
         st_ff.oe_n  <= 1'b1;
         st_ff.we_n  <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // pins come straight from flip-flops so the memory never sees a decode glitch
   assign req_ready                = (st_ff.state == ST_IDLE);
   assign rsp_valid                = st_ff.rvalid;
   assign rsp_rdata                = st_ff.rdata;
   assign mem_addr                 = st_ff.addr;
   assign chip_select_low_active_n = st_ff.cs_n;
   assign chip_select_high_active  = st_ff.cs;
   assign output_enable_n          = st_ff.oe_n;
   assign write_strobe_n           = st_ff.we_n;
   assign mem_data_out             = st_ff.wdata;
   assign mem_data_oe              = st_ff.doe;

   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_strobe_fall;
      $fell(write_strobe_n);
   endsequence

   sequence s_take_write;
      req_valid && req_ready && req_write;
   endsequence

   sequence s_take_read;
      req_valid && req_ready && !req_write;
   endsequence

   // a pulse cut short by reset is not a finished write
   sequence s_strobe_rise;
      $rose(write_strobe_n) && !$past(srst);
   endsequence

   a_addr_stable_strobe: assert property ($changed(mem_addr) |-> write_strobe_n)
      else $error("address changed with strobe low");
   a_read_no_strobe: assert property (!output_enable_n |-> write_strobe_n)
      else $error("strobe low during read");
   a_write_selected: assert property (!write_strobe_n |->
         !chip_select_low_active_n && chip_select_high_active && mem_data_oe)
      else $error("strobe low outside selected write");
   // writes run output-disabled; width checked is WP_CYC, from the larger of T_WP_PS and T_WHZ_PS + T_DW_PS
   a_strobe_width: assert property (s_strobe_rise |-> $past(!write_strobe_n, WP_CYC))
      else $error("write pulse too short");
   a_strobe_quiet: assert property (s_strobe_fall |->
         output_enable_n && $past(output_enable_n))
      else $error("strobe fell with output enabled");
   a_bus_release: assert property (mem_data_oe |->
         output_enable_n && $past(output_enable_n))
      else $error("host drives while device may drive");
   a_write_turn: assert property (s_take_write |-> ##1 !mem_data_oe && write_strobe_n)
      else $error("host drove bus in turnaround cycle");
   a_read_answer: assert property (req_valid && req_ready && !req_write
         |-> ##[1:8] rsp_valid)
      else $error("read answer missing");
   a_read_strobe_high: assert property (s_take_read |-> ##1 write_strobe_n [*2])
      else $error("strobe low during read access");
   a_deselect_idle: assert property (req_ready |-> chip_select_low_active_n &&
         !chip_select_high_active && output_enable_n && write_strobe_n && !mem_data_oe)
      else $error("device left selected in idle");
   a_data_held: assert property (s_strobe_rise |-> mem_data_oe)
      else $error("write data released before strobe rise");
   a_data_stable: assert property (!write_strobe_n |-> $stable(mem_data_out))
      else $error("write data moved under strobe");

endmodule // sram_host_ctrl

// ---- rtl/sram_host_pkg.sv ----
package sram_host_pkg;
   localparam int ADDR_W          = 13;
   localparam int DATA_W          = 9;
   localparam int CLK_PERIOD_PS   = 25000;
   // slowest grade figures; host waits cover all grades
   localparam int T_ACCESS_PS     = 20000;
   localparam int T_WP_PS         = 15000;
   localparam int T_WHZ_PS        = 8000;
   localparam int T_DW_PS         = 10000;
   localparam int T_OHZ_PS        = 8000;
   localparam int ACCESS_CYC      = (T_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WP_MIN_PS       = (T_WP_PS > T_WHZ_PS + T_DW_PS) ? T_WP_PS
                                                                  : T_WHZ_PS + T_DW_PS;
   localparam int WP_CYC          = (WP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TURN_CYC        = (T_OHZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [3:0] CNT_ONE = 4'h1;
endpackage

// ---- dv/sram_async_model.sv ----
module sram_async_model
   import sram_host_pkg::*;
(
   // pins from host
   input  wire logic [ADDR_W-1:0] mem_addr,
   input  wire logic              chip_select_low_active_n,
   input  wire logic              chip_select_high_active,
   input  wire logic              output_enable_n,
   input  wire logic              write_strobe_n,
   input  wire logic [DATA_W-1:0] mem_data_out,
   input  wire logic              mem_data_oe,
   // resolved data wire
   output logic      [DATA_W-1:0] mem_data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic [DATA_W-1:0] last = '0;
   logic              on;
   logic              drv;
   assign on  = !chip_select_low_active_n && chip_select_high_active;
   assign drv = on && !output_enable_n && write_strobe_n;
   always @* if (on && !write_strobe_n) mem[mem_addr] = mem_data_in;
   // contention reads as unknown; a released wire shows the inverse of its last value
   always @* begin
      if (drv && mem_data_oe) mem_data_in = 'x;
      else if (drv) mem_data_in = mem[mem_addr];
      else if (mem_data_oe) mem_data_in = mem_data_out;
      else mem_data_in = ~last;
   end
   always @* if (drv || mem_data_oe) last = mem_data_in;
endmodule // sram_async_model

// ---- dv/async_sram_8kx9_dual_select_test.sv ----
module async_sram_8kx9_dual_select_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sram_host_pkg::*;
   logic              clock, srst, req_valid, req_ready, req_write, rsp_valid;
   logic [ADDR_W-1:0] req_addr, mem_addr, prev_addr;
   logic [DATA_W-1:0] req_wdata, rsp_rdata, mem_data_in, mem_data_out;
   logic              chip_select_low_active_n, chip_select_high_active;
   logic              output_enable_n, write_strobe_n, mem_data_oe;
   int                bad_count, compares;
   sram_host_ctrl i_sram_host_ctrl (
      .clock                    (clock),
      .srst                     (srst),
      .req_valid                (req_valid),
      .req_ready                (req_ready),
      .req_write                (req_write),
      .req_addr                 (req_addr),
      .req_wdata                (req_wdata),
      .rsp_valid                (rsp_valid),
      .rsp_rdata                (rsp_rdata),
      .mem_addr                 (mem_addr),
      .chip_select_low_active_n (chip_select_low_active_n),
      .chip_select_high_active  (chip_select_high_active),
      .output_enable_n          (output_enable_n),
      .write_strobe_n           (write_strobe_n),
      .mem_data_in              (mem_data_in),
      .mem_data_out             (mem_data_out),
      .mem_data_oe              (mem_data_oe)
   );
   sram_async_model i_sram_async_model (
      .mem_addr                 (mem_addr),
      .chip_select_low_active_n (chip_select_low_active_n),
      .chip_select_high_active  (chip_select_high_active),
      .output_enable_n          (output_enable_n),
      .write_strobe_n           (write_strobe_n),
      .mem_data_out             (mem_data_out),
      .mem_data_oe              (mem_data_oe),
      .mem_data_in              (mem_data_in)
   );
   initial begin
      clock = 0;
      forever #12.5 clock = ~clock;
   end
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t: pin got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic chk_addr(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t: address got %h exp %h", $time, got, exp);
      end
   endtask
   task conclude;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task issue(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(negedge clock);
      while (req_ready !== 1'b1) begin
         @(negedge clock);
         n++;
         if (n > 20) begin
            bad_count++;
            $display("MISMATCH %0t: ready never returned", $time);
            conclude();
         end
      end
      @(posedge clock);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr  <= a;
      req_wdata <= d;
      @(posedge clock);
      req_valid <= 1'b0;
   endtask
   // answer stands in the second cycle after the taking edge
   task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      issue(1'b0, a, '0);
      @(negedge clock);
      chk_bit(req_ready, 1'b0);
      chk_bit(output_enable_n, 1'b0);
      chk_bit(rsp_valid, 1'b0);
      @(negedge clock);
      chk_bit(rsp_valid, 1'b1);
      chk(rsp_rdata, exp);
   endtask
   // write pins walked cycle by cycle after the taking edge
   task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      issue(1'b1, a, d);
      @(negedge clock);
      chk_bit(req_ready, 1'b0);
      chk_bit(chip_select_low_active_n, 1'b0);
      chk_bit(output_enable_n, 1'b1);
      chk_bit(write_strobe_n, 1'b1);
      chk_bit(mem_data_oe, 1'b0);
      @(negedge clock);
      chk_bit(write_strobe_n, 1'b0);
      chk_addr(mem_addr, a);
      chk(mem_data_out, d);
      @(negedge clock);
      chk_bit(write_strobe_n, 1'b1);
      chk_bit(mem_data_oe, 1'b1);
   endtask
   task t_idle;
      @(negedge clock);
      chk_bit(chip_select_low_active_n, 1'b1);
      chk_bit(chip_select_high_active, 1'b0);
      chk_bit(output_enable_n, 1'b1);
      chk_bit(write_strobe_n, 1'b1);
      chk_bit(mem_data_oe, 1'b0);
      chk_bit(req_ready, 1'b1);
      chk_bit(rsp_valid, 1'b0);
      $display("idle test done");
   endtask
   task t_rw;
      wr(13'h0000, 9'h1a5);
      wr(13'h1fff, 9'h05a);
      wr(13'h0a55, 9'h100);
      rd(13'h0000, 9'h1a5);
      rd(13'h1fff, 9'h05a);
      wr(13'h0000, 9'h0ff);
      rd(13'h0000, 9'h0ff);
      $display("write read test done");
   endtask
   // a request offered while busy must leave no trace
   task t_refuse;
      issue(1'b1, 13'h0123, 9'h111);
      @(posedge clock);
      req_valid <= 1'b1;
      req_addr  <= 13'h0a55;
      req_wdata <= 9'h0aa;
      @(posedge clock);
      req_valid <= 1'b0;
      rd(13'h0a55, 9'h100);
      rd(13'h0123, 9'h111);
      $display("refuse test done");
   endtask
   // reset landing on a strobe pulse must leave strobe, both selects and data drive idle at once
   task t_reset;
      issue(1'b1, 13'h0777, 9'h0cc);
      @(posedge clock);
      srst <= 1'b1;
      @(posedge clock);
      srst <= 1'b0;
      @(negedge clock);
      chk_bit(write_strobe_n, 1'b1);
      chk_bit(chip_select_low_active_n, 1'b1);
      chk_bit(chip_select_high_active, 1'b0);
      chk_bit(mem_data_oe, 1'b0);
      chk_bit(req_ready, 1'b1);
      rd(13'h0123, 9'h111);
      $display("reset test done");
   endtask
   always @(negedge clock) begin
      if (!srst && write_strobe_n === 1'b0) begin
         chk_addr(mem_addr, prev_addr);
         chk_bit(output_enable_n, 1'b1);
         chk_bit(mem_data_oe, 1'b1);
      end
      if (!srst && output_enable_n === 1'b0) chk_bit(write_strobe_n, 1'b1);
      prev_addr = mem_addr;
   end
   initial begin
      srst = 1;
      req_valid = 0;
      req_write = 0;
      req_addr = '0;
      req_wdata = '0;
      bad_count = 0;
      compares = 0;
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      t_idle();
      t_rw();
      t_refuse();
      t_reset();
      conclude();
   end
endmodule // async_sram_8kx9_dual_select_test
